/* inc/xls_regs.vh */
`ifndef XLS_REGS_VH
`define XLS_REGS_VH
`define XLS_LINK_OFS        12'h0C0
`define XLS_SLOT_OFS        12'h0C4
`define XLS_PWR_LSB         0
`define XLS_CPL_BIT         3
`define XLS_DIS_BIT         4
`define XLS_RETRAIN_BIT     5
`define XLS_CCLK_BIT        6
`define XLS_XSYNC_BIT       7
`define XLS_SPEED_LSB       16
`define XLS_WIDTH_LSB       20
`define XLS_TERR_BIT        26
`define XLS_TRAIN_BIT       27
`define XLS_SCLK_BIT        28
`define XLS_SPEED_2G5       4'h1
`define XLS_WIDTH_X1        6'h01
`define XLS_ATTN_BTN_BIT    0
`define XLS_LATCH_BIT       2
`define XLS_ATTN_IND_BIT    3
`define XLS_PWR_IND_BIT     4
`define XLS_HP_CAP_BIT      6
`endif

/* hw/xls_sync.v */
// three-stage synchroniser; output changes when stages two and three agree
module xls_sync
(
  input  wire clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule // xls_sync

/* hw/xls_regs.v */
`include "xls_regs.vh"

module xls_regs
(
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // straps and link state inputs (pins)
  input  wire        reverse_mode,
  input  wire        hot_plug_strap,
  input  wire        train_error,
  input  wire        training,
  // link control outputs
  output reg  [1:0]  pwr_entry,
  output reg         link_disable,
  output reg         retrain,
  output reg         common_clk,
  output reg         ext_sync
);
  wire rev_s;
  wire hp_s;
  wire terr_s;
  wire train_s;
  reg  hp_pres_reg;
  wire wr_en;
  wire rd_en;
  reg  [31:0] rd_next;

  xls_sync u_rev   (.clk(clk), .rstn(rstn), .din(reverse_mode),   .dout(rev_s));
  xls_sync u_hp    (.clk(clk), .rstn(rstn), .din(hot_plug_strap), .dout(hp_s));
  xls_sync u_terr  (.clk(clk), .rstn(rstn), .din(train_error),    .dout(terr_s));
  xls_sync u_train (.clk(clk), .rstn(rstn), .din(training),       .dout(train_s));

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  function [31:0] slot_word;
    input hp;
    begin
      slot_word = 32'h0;
      slot_word[`XLS_ATTN_BTN_BIT] = hp;
      slot_word[`XLS_LATCH_BIT]    = hp;
      slot_word[`XLS_ATTN_IND_BIT] = hp;
      slot_word[`XLS_PWR_IND_BIT]  = hp;
      slot_word[`XLS_HP_CAP_BIT]   = hp;
    end
  endfunction

  // reverse_mode and hot_plug_strap ANDed and registered each clock after reset release, through the synchronisers
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      hp_pres_reg    <= 1'b0;
    end
    else
    begin
      hp_pres_reg    <= rev_s & hp_s;
    end
  end

  always @*
  begin
    rd_next = 32'h0;
    case (paddr)
      `XLS_LINK_OFS:
      begin
        rd_next[`XLS_PWR_LSB +: 2]   = pwr_entry;
        rd_next[`XLS_CPL_BIT]        = 1'b0;
        rd_next[`XLS_DIS_BIT]        = link_disable;
        rd_next[`XLS_RETRAIN_BIT]    = retrain;
        rd_next[`XLS_CCLK_BIT]       = common_clk;
        rd_next[`XLS_XSYNC_BIT]      = ext_sync;
        rd_next[`XLS_SPEED_LSB +: 4] = `XLS_SPEED_2G5;
        rd_next[`XLS_WIDTH_LSB +: 6] = `XLS_WIDTH_X1;
        rd_next[`XLS_TERR_BIT]       = terr_s;
        rd_next[`XLS_TRAIN_BIT]      = train_s;
        rd_next[`XLS_SCLK_BIT]       = 1'b1;
      end
      `XLS_SLOT_OFS:
        rd_next = slot_word(hp_pres_reg);
      default:
        rd_next = 32'h0;
    endcase
  end

  // no wait state: setup, then access with pready in the next cycle
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      prdata       <= 32'h0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      pwr_entry    <= 2'b00;
      link_disable <= 1'b0;
      retrain      <= 1'b0;
      common_clk   <= 1'b0;
      ext_sync     <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr != `XLS_LINK_OFS) && (paddr != `XLS_SLOT_OFS);
      if (rd_en)
        prdata <= rd_next;
      if (wr_en && paddr == `XLS_LINK_OFS)
      begin
        pwr_entry  <= pwdata[`XLS_PWR_LSB +: 2];
        common_clk <= pwdata[`XLS_CCLK_BIT];
        ext_sync   <= pwdata[`XLS_XSYNC_BIT];
        if (rev_s)
        begin
          link_disable <= pwdata[`XLS_DIS_BIT];
          retrain      <= pwdata[`XLS_RETRAIN_BIT];
        end
      end
    end
  end
endmodule // xls_regs

/* sim/xls_props.sv */
module xls_props(
  input wire clk, rstn, psel, penable, pwrite, pready, pslverr, reverse_mode,
  input wire link_disable, retrain, common_clk, ext_sync,
  input wire [1:0] pwr_entry,
  input wire [11:0] paddr,
  input wire [31:0] prdata);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rd_ctl;
    pready && !pwrite && paddr == 12'h0C0;
  endsequence
  a_ans_next: assert property (psel && !penable |=> pready) else $error("no answer");
  a_ctl_view: assert property (rd_ctl |-> prdata[7:0] ==
    {ext_sync, common_clk, retrain, link_disable, 2'h0, pwr_entry}) else $error("ctl");
  a_speed_code: assert property (rd_ctl |-> prdata[19:16] == 4'h1) else $error("speed");
  a_fwd_lock: assert property (!reverse_mode [*6] |-> $stable({link_disable, retrain}))
    else $error("fwd");
  a_rsv_zero: assert property (pready && !pwrite && paddr == 12'h0C4 |-> prdata[31:7] == 25'h0)
    else $error("rsv");
  a_unmap_err: assert property (pready && paddr > 12'h0C4 |-> pslverr) else $error("err");
endmodule // xls_props

/* sim/xls_host.sv */
module xls_host(
  input wire clk, pready,
  input wire [31:0] prdata,
  output logic psel = 0, penable = 0, pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'h0;
  endtask
endmodule // xls_host

/* sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rev = 0, hp = 0, te = 0, tr = 0;
  wire psel, penable, pwrite, pready;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  logic [31:0] r, d;
  logic [7:0] lc = 0;
  int err_count = 0, checks_done = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  xls_regs xls_regs_i(.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr(), .reverse_mode(rev), .hot_plug_strap(hp), .train_error(te),
    .training(tr), .pwr_entry(), .link_disable(), .retrain(), .common_clk(), .ext_sync());
  xls_host xls_host_i(.clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  task chk(input logic [31:0] a, e);
    checks_done++;
    if (a !== e) begin err_count++; $display("mismatch t=%0t %h %h", $time, a, e); end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 2000) begin err_count++; conclude; end
  initial begin
    void'($urandom(32'h7D2B0607));
    {rev, hp} <= 2'($urandom);
    repeat (20) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (i > 0) {rev, hp, te, tr} <= 4'($urandom);
      repeat (8) @(posedge clk);
      xls_host_i.xfer(0, 12'h0C0, 0, r);
      chk(r, {3'h0, 1'b1, tr, te, 6'h01, 4'h1, 8'h00, lc});
      xls_host_i.xfer(0, 12'h0C4, 0, r);
      chk(r, (rev & hp) ? 32'h5D : 32'h0);
      xls_host_i.xfer(0, 12'h0C8, 0, r);
      chk(r, 32'h0);
      d = $urandom;
      xls_host_i.xfer(1, 12'h0C0, d, r);
      lc = {d[7:6], rev ? d[5:4] : lc[5:4], 2'h0, d[1:0]};
      $display("test %0d done", i);
    end
    conclude;
  end
endmodule // tb
bind xls_regs xls_props xls_props_i(.*);
